// ===== src/ma_overhead_pkg.sv
// Package: register map, field positions and codes for the overhead byte block
package ma_overhead_pkg;
  localparam logic [7:0] ADDR_RX_OPERATOR = 8'h1A;
  localparam logic [7:0] ADDR_RX_GENERAL  = 8'h1B;
  localparam logic [7:0] ADDR_TX_GENERAL  = 8'h35;
  localparam logic [7:0] ADDR_TX_OPERATOR = 8'h37;
  localparam logic [7:0] ADDR_CONTROL     = 8'h38;
  localparam logic [7:0] ADDR_STATUS      = 8'h39;
  localparam logic [7:0] ADDR_RX_MAINT    = 8'h3A;
  localparam int BIT_RRF    = 7;
  localparam int BIT_RBE    = 6;
  localparam int PT_MSB     = 5;
  localparam int PT_LSB     = 3;
  localparam int BIT_TIMING = 0;
  localparam int CTL_LINK_OPERATOR = 0;
  localparam int CTL_LINK_GENERAL  = 1;
  localparam int CTL_TIMING        = 2;
  localparam int CTL_PT_LSB        = 3;
  localparam logic [7:0] RESET_TX_OPERATOR = 8'h00;
  localparam logic [7:0] RESET_TX_GENERAL  = 8'h00;
  localparam logic [7:0] RESET_CONTROL     = 8'h0C;
  localparam logic [2:0] PT_UNEQUIPPED = 3'h0;
  localparam logic [2:0] PT_EQUIPPED   = 3'h1;
  localparam logic [2:0] PT_ATM        = 3'h2;
  localparam logic [2:0] PT_TU12       = 3'h3;
endpackage : ma_overhead_pkg

// ===== src/link_skid_buffer.sv
// Two-entry valid/ready buffer for link message octets
`timescale 1ns/1ps
module link_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] count;
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o  = (count != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // An accepted octet must be visible on the far side next cycle
  push_seen_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    push |=> out_valid_o) else $error("pushed octet lost");
endmodule : link_skid_buffer

// ===== src/ma_overhead_framer.sv
// Maintenance, operator and general-purpose overhead byte handling for E3 frames
// Overview of operation
// - Any local loss, out-of-frame or alarm condition sets remote failure flag bit 7.
// - Remote failure flag stays one in each frame while the fault persists.
// - Without receive fault the remote failure flag is sent as zero.
// - An error monitor mismatch sets remote block error flag bit 6.
// - A passing error monitor check sends the remote block error flag as zero.
// - Bits five to three carry the three-bit payload type code.
// - Bit 0 is zero when timing is reference-traceable, else one.
// - Operator or general byte may carry one link message octet per frame.
// - Unused operator byte is sent from the transmit operator register.
// - Each received operator byte is captured into the receive operator register.
// - Unused general byte is sent from the transmit general register.
// - Each received general byte is captured into the receive general register.
// - Local parity of a frame is compared with next frame's monitor byte.
`timescale 1ns/1ps
module ma_overhead_framer
  import ma_overhead_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic       loss_of_signal_condition_i,
  input  wire logic       out_of_frame_condition_i,
  input  wire logic       alarm_indication_condition_i,
  input  wire logic       rx_frame_start_i,
  input  wire logic [7:0] rx_parity_i,
  input  wire logic       rx_monitor_valid_i,
  input  wire logic [7:0] rx_error_monitor_byte_i,
  input  wire logic       rx_overhead_valid_i,
  input  wire logic [7:0] rx_maintenance_byte_i,
  input  wire logic [7:0] rx_operator_byte_i,
  input  wire logic [7:0] rx_general_byte_i,
  input  wire logic       tx_overhead_req_i,
  output logic [7:0]      tx_maintenance_byte_o,
  output logic [7:0]      tx_operator_byte_o,
  output logic [7:0]      tx_general_byte_o,
  output logic            tx_overhead_valid_o,
  input  wire logic [7:0] link_tx_data_i,
  input  wire logic       link_tx_valid_i,
  output logic            link_tx_ready_o,
  output logic [7:0]      link_rx_data_o,
  output logic            link_rx_valid_o
);
  logic [7:0] tx_operator_byte_value;
  logic [7:0] tx_general_channel_value;
  logic [7:0] rx_operator_byte_capture;
  logic [7:0] rx_general_channel_capture;
  logic [7:0] rx_maint_capture;
  logic [7:0] control;
  logic [7:0] held_parity;
  logic       parity_held;
  logic       block_error;
  logic       remote_fault;
  logic [7:0] buf_data;
  logic       buf_valid;
  logic       buf_pop;
  logic       link_on;
  logic [7:0] next_maint;

  link_skid_buffer #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (link_tx_data_i),
    .in_valid_i  (link_tx_valid_i),
    .in_ready_o  (link_tx_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop)
  );

  // Register writes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_operator_byte_value   <= RESET_TX_OPERATOR;
      tx_general_channel_value <= RESET_TX_GENERAL;
      control                  <= RESET_CONTROL;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_TX_OPERATOR: tx_operator_byte_value <= wdata_i;
        ADDR_TX_GENERAL:  tx_general_channel_value <= wdata_i;
        ADDR_CONTROL:     control <= {2'h0, wdata_i[5:0]};
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_RX_OPERATOR: rdata_o <= rx_operator_byte_capture;
        ADDR_RX_GENERAL:  rdata_o <= rx_general_channel_capture;
        ADDR_TX_OPERATOR: rdata_o <= tx_operator_byte_value;
        ADDR_TX_GENERAL:  rdata_o <= tx_general_channel_value;
        ADDR_CONTROL:     rdata_o <= control;
        ADDR_STATUS:      rdata_o <= {6'h00, block_error, remote_fault};
        ADDR_RX_MAINT:    rdata_o <= rx_maint_capture;
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Receive fault is a live level so the flag tracks it frame by frame
  assign remote_fault = loss_of_signal_condition_i || out_of_frame_condition_i
                        || alarm_indication_condition_i;

  // Parity of a frame waits for the monitor byte of the next frame
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_parity <= 8'h00;
      parity_held <= 1'b0;
      block_error <= 1'b0;
    end else begin
      if (rx_frame_start_i) begin
        held_parity <= rx_parity_i;
        parity_held <= 1'b1;
      end
      if (rx_monitor_valid_i && parity_held) begin
        block_error <= (rx_error_monitor_byte_i != held_parity);
      end
    end
  end

  // Captures of the received overhead bytes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_operator_byte_capture   <= 8'h00;
      rx_general_channel_capture <= 8'h00;
      rx_maint_capture           <= 8'h00;
    end else if (rx_overhead_valid_i) begin
      rx_operator_byte_capture   <= rx_operator_byte_i;
      rx_general_channel_capture <= rx_general_byte_i;
      rx_maint_capture           <= {rx_maintenance_byte_i[7:3], 2'h0, rx_maintenance_byte_i[0]};
    end
  end

  // Received link octet from whichever byte carries the channel
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_rx_valid_o <= 1'b0;
      link_rx_data_o  <= 8'h00;
    end else begin
      link_rx_valid_o <= rx_overhead_valid_i && link_on;
      if (rx_overhead_valid_i && link_on) begin
        link_rx_data_o <= control[CTL_LINK_OPERATOR] ? rx_operator_byte_i : rx_general_byte_i;
      end
    end
  end

  // Operator byte wins if both selects are set; only one channel exists
  assign link_on = control[CTL_LINK_OPERATOR] || control[CTL_LINK_GENERAL];
  assign buf_pop = tx_overhead_req_i && link_on;

  always_comb begin
    next_maint = 8'h00;
    next_maint[BIT_RRF] = remote_fault;
    next_maint[BIT_RBE] = block_error;
    next_maint[PT_MSB:PT_LSB] = control[CTL_PT_LSB +: 3];
    next_maint[BIT_TIMING] = control[CTL_TIMING];
  end

  // Transmit overhead bytes, built once per frame request
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_maintenance_byte_o <= 8'h00;
      tx_operator_byte_o    <= 8'h00;
      tx_general_byte_o     <= 8'h00;
      tx_overhead_valid_o   <= 1'b0;
    end else begin
      tx_overhead_valid_o <= tx_overhead_req_i;
      if (tx_overhead_req_i) begin
        tx_maintenance_byte_o <= next_maint;
        // Empty buffer sends idle zero rather than stalling the frame
        if (control[CTL_LINK_OPERATOR]) begin
          tx_operator_byte_o <= buf_valid ? buf_data : 8'h00;
        end else begin
          tx_operator_byte_o <= tx_operator_byte_value;
        end
        if (control[CTL_LINK_GENERAL] && !control[CTL_LINK_OPERATOR]) begin
          tx_general_byte_o <= buf_valid ? buf_data : 8'h00;
        end else begin
          tx_general_byte_o <= tx_general_channel_value;
        end
      end
    end
  end

  rrf_follows_fault_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && remote_fault |=> tx_maintenance_byte_o[BIT_RRF]) else $error("rrf not set");
  rrf_clears_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && !remote_fault |=> !tx_maintenance_byte_o[BIT_RRF]) else $error("rrf not clear");
  rrf_holds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    remote_fault && $past(remote_fault) && tx_overhead_valid_o |-> tx_maintenance_byte_o[7])
    else $error("rrf dropped");
  rbe_mismatch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_monitor_valid_i && parity_held && rx_error_monitor_byte_i != held_parity |=> block_error)
    else $error("rbe not set");
  rbe_sent_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && block_error |=> tx_maintenance_byte_o[BIT_RBE]) else $error("rbe not sent");
  rbe_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_monitor_valid_i && parity_held && rx_error_monitor_byte_i == held_parity |=> !block_error)
    else $error("rbe not cleared");
  maint_fields_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i |=> tx_maintenance_byte_o[5:3] == $past(control[5:3])) else $error("payload type");
  timing_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i |=> tx_maintenance_byte_o[0] == $past(control[CTL_TIMING])) else $error("timing bit");
  dependent_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_valid_o |-> tx_maintenance_byte_o[2:1] == 2'h0) else $error("dependent bits");
  operator_tx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && !control[0] |=> tx_operator_byte_o == $past(tx_operator_byte_value))
    else $error("operator byte");
  general_tx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && !control[1] |=> tx_general_byte_o == $past(tx_general_channel_value))
    else $error("general byte");
  operator_rx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_overhead_valid_i |=> rx_operator_byte_capture == $past(rx_operator_byte_i))
    else $error("operator capture");
  operator_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_RX_OPERATOR |=> rdata_o == $past(rx_operator_byte_capture))
    else $error("operator read");
  general_rx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_overhead_valid_i |=> rx_general_channel_capture == $past(rx_general_byte_i))
    else $error("general capture");
  link_octet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_overhead_req_i && control[0] && buf_valid |=> tx_operator_byte_o == $past(buf_data))
    else $error("link octet");

  fault_frame_c: cover property (@(posedge mclk_i) tx_overhead_valid_o && tx_maintenance_byte_o[7]);
  block_error_c: cover property (@(posedge mclk_i) tx_overhead_valid_o && tx_maintenance_byte_o[6]);
  link_full_c: cover property (@(posedge mclk_i) !link_tx_ready_o ##1 buf_pop);
endmodule : ma_overhead_framer

// ===== bench/remote_framer_model.sv
// Far-end framer model: judges remote receive failure from outbound frames
`timescale 1ns/1ps
module remote_framer_model #(
  parameter int FAIL_FRAMES = 3
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       frame_valid_i,
  input  wire logic [7:0] maint_byte_i,
  output logic            far_failure_o
);
  int unsigned run_len;
  // One clean frame restarts the run, so a single glitch never declares failure
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_len       <= 0;
      far_failure_o <= 1'b0;
    end else if (frame_valid_i) begin
      if (maint_byte_i[7]) begin
        run_len       <= run_len + 1;
        far_failure_o <= (run_len + 1 >= FAIL_FRAMES);
      end else begin
        run_len       <= 0;
        far_failure_o <= 1'b0;
      end
    end
  end
endmodule : remote_framer_model

// ===== bench/tb_top.sv
// Self-checking bench for the overhead byte block
`timescale 1ns/1ps
module tb_top import ma_overhead_pkg::*; ;
  logic       mclk_i, rst_n_i, wr_i, rd_i, fs, mv, ov, req, lvalid;
  logic [2:0] cond;
  logic [7:0] addr_i, wdata_i, par, mon, r_ma, r_op, r_gc, ldata, rd_v;
  logic [7:0] rdata_o, tx_ma, tx_op, tx_gc, lrx_data;
  logic       tx_vld, lready, lrx_vld, far_fail;
  int         fails, total_checks, cycles;

  ma_overhead_framer DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .loss_of_signal_condition_i(cond[0]),
    .out_of_frame_condition_i(cond[1]), .alarm_indication_condition_i(cond[2]),
    .rx_frame_start_i(fs), .rx_parity_i(par), .rx_monitor_valid_i(mv), .rx_error_monitor_byte_i(mon),
    .rx_overhead_valid_i(ov), .rx_maintenance_byte_i(r_ma), .rx_operator_byte_i(r_op),
    .rx_general_byte_i(r_gc), .tx_overhead_req_i(req), .tx_maintenance_byte_o(tx_ma),
    .tx_operator_byte_o(tx_op), .tx_general_byte_o(tx_gc), .tx_overhead_valid_o(tx_vld),
    .link_tx_data_i(ldata), .link_tx_valid_i(lvalid), .link_tx_ready_o(lready),
    .link_rx_data_o(lrx_data), .link_rx_valid_o(lrx_vld));
  remote_framer_model far_end (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .frame_valid_i(tx_vld),
    .maint_byte_i(tx_ma), .far_failure_o(far_fail));

  always #25 mclk_i = ~mclk_i;
  // Ceiling well above the roughly 155 cycles the sequence needs
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i); wr_i <= 1'b0;
  endtask : reg_wr
  // Read data stand for one cycle only, so sample right after the taking edge
  task automatic reg_rd(input logic [7:0] a);
    @(posedge mclk_i); addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i); rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask : reg_rd
  task automatic frame();
    @(posedge mclk_i); req <= 1'b1;
    @(posedge mclk_i); req <= 1'b0;
    #1 chk({7'h00, tx_vld}, 8'h01);
  endtask : frame
  task automatic rx_frame(input logic [7:0] m, input logic [7:0] o, input logic [7:0] g);
    @(posedge mclk_i); ov <= 1'b1; r_ma <= m; r_op <= o; r_gc <= g;
    @(posedge mclk_i); ov <= 1'b0;
    #1;
  endtask : rx_frame
  task automatic push(input logic [7:0] d);
    @(posedge mclk_i); ldata <= d; lvalid <= 1'b1;
    @(posedge mclk_i); lvalid <= 1'b0;
  endtask : push
  task automatic parity(input logic [7:0] p, input logic [7:0] m);
    @(posedge mclk_i); fs <= 1'b1; par <= p;
    @(posedge mclk_i); fs <= 1'b0; mv <= 1'b1; mon <= m;
    @(posedge mclk_i); mv <= 1'b0;
  endtask : parity

  task automatic t_tx_regs();
    reg_rd(ADDR_TX_OPERATOR); chk(rd_v, RESET_TX_OPERATOR);
    reg_wr(ADDR_TX_OPERATOR, 8'hA5);
    reg_wr(ADDR_TX_GENERAL, 8'h5A);
    reg_rd(ADDR_TX_GENERAL); chk(rd_v, 8'h5A);
    reg_rd(8'h50); chk(rd_v, 8'h00);
    frame();
    chk(tx_op, 8'hA5);
    chk(tx_gc, 8'h5A);
    chk(tx_ma, 8'h09);
  endtask : t_tx_regs
  task automatic t_rx_capture();
    rx_frame(8'h00, 8'h12, 8'h34);
    rx_frame(8'hFF, 8'h3C, 8'hC3);
    reg_rd(ADDR_RX_OPERATOR); chk(rd_v, 8'h3C);
    reg_rd(ADDR_RX_GENERAL); chk(rd_v, 8'hC3);
    reg_wr(ADDR_RX_OPERATOR, 8'hFF);
    reg_rd(ADDR_RX_OPERATOR); chk(rd_v, 8'h3C);
    reg_rd(ADDR_RX_MAINT); chk(rd_v, 8'hF9);
  endtask : t_rx_capture
  task automatic t_fault();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i); cond <= 3'b001 << i;
      repeat (3) begin
        frame(); chk({7'h00, tx_ma[BIT_RRF]}, 8'h01);
      end
      reg_rd(ADDR_STATUS); chk(rd_v, 8'h01);
      // Far end updates on the edge itself, so look once it has settled
      @(posedge mclk_i); cond <= 3'b000;
      #1 chk({7'h00, far_fail}, 8'h01);
      frame(); chk({7'h00, tx_ma[BIT_RRF]}, 8'h00);
    end
  endtask : t_fault
  task automatic t_block_err();
    parity(8'h5A, 8'h5B);
    frame(); chk({7'h00, tx_ma[BIT_RBE]}, 8'h01);
    reg_rd(ADDR_STATUS); chk(rd_v, 8'h02);
    parity(8'h11, 8'h11);
    frame(); chk({7'h00, tx_ma[BIT_RBE]}, 8'h00);
  endtask : t_block_err
  task automatic t_payload();
    logic [2:0] codes [4];
    codes = '{PT_UNEQUIPPED, PT_EQUIPPED, PT_ATM, PT_TU12};
    for (int i = 0; i < 8; i++) begin
      reg_wr(ADDR_CONTROL, {2'b00, codes[i/2], i[0], 2'b00});
      reg_rd(ADDR_CONTROL); chk(rd_v, {2'b00, codes[i/2], i[0], 2'b00});
      frame(); chk(tx_ma, {2'b00, codes[i/2], 2'b00, i[0]});
    end
  endtask : t_payload
  task automatic t_link();
    reg_wr(ADDR_CONTROL, 8'h09);
    push(8'h11);
    push(8'h22);
    // Third octet must be held off while both entries are in use
    @(posedge mclk_i); ldata <= 8'h33; lvalid <= 1'b1;
    #1 chk({7'h00, lready}, 8'h00);
    @(posedge mclk_i); lvalid <= 1'b0;
    frame(); chk(tx_op, 8'h11);
    chk(tx_gc, 8'h5A);
    frame(); chk(tx_op, 8'h22);
    frame(); chk(tx_op, 8'h00);
    rx_frame(8'h00, 8'h77, 8'h88); chk({lrx_vld, 7'h00}, 8'h80);
    chk(lrx_data, 8'h77);
    reg_wr(ADDR_CONTROL, 8'h0A);
    push(8'h44);
    frame(); chk(tx_gc, 8'h44);
    chk(tx_op, 8'hA5);
    rx_frame(8'h00, 8'h99, 8'h66); chk(lrx_data, 8'h66);
  endtask : t_link
  // Mid-run reset must bring outputs and registers back to their reset values
  task automatic t_reset();
    @(posedge mclk_i); rst_n_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk(tx_ma, 8'h00);
    chk(tx_op, 8'h00);
    chk({7'h00, lready}, 8'h01);
    @(posedge mclk_i); rst_n_i <= 1'b1;
    reg_rd(ADDR_CONTROL); chk(rd_v, RESET_CONTROL);
    reg_rd(ADDR_TX_OPERATOR); chk(rd_v, RESET_TX_OPERATOR);
  endtask : t_reset

  task automatic final_report();
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    {mclk_i, rst_n_i, wr_i, rd_i, fs, mv, ov, req, lvalid, cond} = '0;
    {addr_i, wdata_i, par, mon, r_ma, r_op, r_gc, ldata} = '0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_tx_regs();
    t_rx_capture();
    t_fault();
    t_block_err();
    t_payload();
    t_link();
    t_reset();
    final_report();
  end
endmodule : tb_top
